//--- rtl/fmlat_event_latch.sv
/*
 sticky event latch, one bit per event, cleared by a read strobe.
 assumes events and the clear strobe are on clk; a set in the clear cycle wins.
*/
`timescale 1ns/1ns
`default_nettype none
module fmlat_event_latch #(
    parameter int W = 8
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // events and clear
    input wire logic [W-1:0] evt,
    input wire logic clr,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] lat;
    } fmlat_latch_s;

    fmlat_latch_s st_q;
    fmlat_latch_s st_d;
    logic [W-1:0] nxt;

    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            assign nxt[i] = evt[i] | (st_q.lat[i] & ~clr);
        end
    endgenerate

    always_comb begin
        st_d = st_q;
        st_d.lat = nxt;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign q = st_q.lat;

    chk_set_wins_clear: assert property (@(posedge clk) disable iff (rst)
        (clr && (evt != '0)) |=> ((q & $past(evt)) == $past(evt)))
        else $error("event lost in clear cycle");
endmodule // fmlat_event_latch
`default_nettype wire

//--- rtl/fmlat_pin_sync.sv
/*
 three-stage synchroniser for fault levels from the analog detectors.
 assumes inputs are asynchronous levels; a change is taken once stages two and three agree.
*/
`timescale 1ns/1ns
`default_nettype none
module fmlat_pin_sync #(
    parameter int W = 38
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // levels
    input wire logic [W-1:0] raw,
    output logic [W-1:0] val
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
        logic [W-1:0] s3;
        logic [W-1:0] val;
    } fmlat_sync_s;

    fmlat_sync_s st_q;
    fmlat_sync_s st_d;

    always_comb begin
        st_d = st_q;
        st_d.s1 = raw;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        for (int i = 0; i < W; i++) begin
            if (st_q.s2[i] == st_q.s3[i]) begin
                st_d.val[i] = st_q.s3[i];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign val = st_q.val;

    // judged per bit: one lane settling must not be blamed on another still in flight
    chk_sync_agree_only: assert property (@(posedge clk) disable iff (rst)
        ((st_q.val ^ $past(st_q.val)) & ($past(st_q.s2) ^ $past(st_q.s3))) == '0)
        else $error("synchronised level moved without agreement");
endmodule // fmlat_pin_sync
`default_nettype wire

//--- rtl/fmlat_pkg.sv
/*
 fault event mask and latch: register offsets, reset values and field positions.
 assumes an 8-bit register address and 8-bit data from the control interface.
*/
package fmlat_pkg;
    // register offsets
    localparam logic [7:0] FMLAT_OFS_CHMASK = 8'h30;
    localparam logic [7:0] FMLAT_OFS_MONMASK = 8'h33;
    localparam logic [7:0] FMLAT_OFS_SYSLAT = 8'h34;
    localparam logic [7:0] FMLAT_OFS_SUMMARY = 8'h35;
    localparam logic [7:0] FMLAT_OFS_IN1 = 8'h36;
    localparam logic [7:0] FMLAT_OFS_IN2 = 8'h37;
    localparam logic [7:0] FMLAT_OFS_OUT1 = 8'h38;
    localparam logic [7:0] FMLAT_OFS_OUT2 = 8'h39;
    localparam logic [7:0] FMLAT_OFS_MONLAT = 8'h3c;
    // reset values
    localparam logic [7:0] FMLAT_MONMASK_RST = 8'h30;
    localparam logic [4:0] FMLAT_CHMASK_RST = 5'h01;
    localparam logic [1:0] FMLAT_ADCMASK_RST = 2'h0;
    localparam logic [7:0] FMLAT_RDATA_RST = 8'h00;
    // monitor mask / latch bit positions
    localparam int FMLAT_MON_GPA_HI = 7;
    localparam int FMLAT_MON_GPA_LO = 6;
    localparam int FMLAT_MON_VAD_UP = 5;
    localparam int FMLAT_MON_VAD_DN = 4;
    localparam int FMLAT_MON_MB_SHORT = 3;
    localparam int FMLAT_MON_MB_HI = 2;
    localparam int FMLAT_MON_MB_LO = 1;
    localparam int FMLAT_MON_MB_OV = 0;
    // system event latch fields, bits 7..3
    localparam int FMLAT_SYS_MSB = 7;
    localparam int FMLAT_SYS_LSB = 3;
    localparam int FMLAT_SYS_W = 5;
    localparam int FMLAT_SYS_CLKERR = 4;
    localparam int FMLAT_SYS_PLL = 3;
    localparam int FMLAT_SYS_BOOST_OT = 2;
    localparam int FMLAT_SYS_BOOST_OC = 1;
    localparam int FMLAT_SYS_BOOST_MO = 0;
    // channel fields
    localparam int FMLAT_MON_W = 8;
    localparam int FMLAT_IN_W = 8;
    localparam int FMLAT_OUT_W = 4;
    localparam int FMLAT_OUT_MSB = 7;
    localparam int FMLAT_OUT_LSB = 4;
    localparam int FMLAT_ADCM_MSB = 3;
    localparam int FMLAT_ADCM_LSB = 2;
    localparam int FMLAT_CHM_MSB = 7;
    localparam int FMLAT_CHM_LSB = 3;
    localparam int FMLAT_CHM_VBAT = 0;
    localparam logic [2:0] FMLAT_RSVD3 = 3'h0;
    localparam logic [1:0] FMLAT_RSVD2 = 2'h0;
    localparam logic [3:0] FMLAT_RSVD4 = 4'h0;
    // packed raw fault vector layout
    localparam int FMLAT_RAW_SYS = 0;
    localparam int FMLAT_RAW_MON = 5;
    localparam int FMLAT_RAW_IN1 = 13;
    localparam int FMLAT_RAW_IN2 = 21;
    localparam int FMLAT_RAW_OUT1 = 29;
    localparam int FMLAT_RAW_OUT2 = 33;
    localparam int FMLAT_RAW_VBAT = 37;
    localparam int FMLAT_RAW_W = 38;
endpackage

//--- rtl/fmlat_top.sv
/*
 fault event mask and latch: monitor mask, system event latch, channel summary,
 per-channel detail latches and the interrupt request.
 assumes the control interface slave presents one-cycle read and write strobes
 with an 8-bit address on clk, and fault detectors drive asynchronous levels.
*/
// How it works
// - mask register at 0x33, reset 0x30
// - bit 7 masks analog input upper threshold
// - bit 6 masks analog input lower threshold
// - bits 5,4 mask voice activity, reset set
// - bit 3 masks bias short circuit
// - bits 2,1 mask bias high/low current
// - bit 0 masks bias overvoltage
// - read-only event latch at 0x34, reset zero
// - bit 7 latches clock error
// - bit 6 latches loop lock
// - bit 5 latches boost overtemperature
// - bit 4 latches boost overcurrent
// - bit 3 latches boost mode-output event
// - reserved bits 2..0 read zero
// - read-only channel summary at 0x35
// - bits 7,6 flag input channel faults
// - bits 5,4 flag output channel faults
// - bit 3 flags battery short below bias
// - input detail latches from 0x36, self clearing
// - 0x30 bit 3 masks battery short, reset set
`timescale 1ns/1ns
`default_nettype none
module fmlat_top
    import fmlat_pkg::*;
(
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // register access from the control interface
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // fault levels from the detectors
    input wire logic [FMLAT_SYS_MSB:FMLAT_SYS_LSB] sys_fault_in,
    input wire logic [7:0] mon_fault_in,
    input wire logic [7:0] in1_fault_in,
    input wire logic [7:0] in2_fault_in,
    input wire logic [FMLAT_OUT_MSB:FMLAT_OUT_LSB] out1_fault_in,
    input wire logic [FMLAT_OUT_MSB:FMLAT_OUT_LSB] out2_fault_in,
    input wire logic vbat_low_short_in,
    // mask of the system events, held by a neighbouring register
    input wire logic [FMLAT_SYS_MSB:FMLAT_SYS_LSB] sys_event_mask,
    // outputs
    output logic [7:0] monitor_fault_mask,
    output logic [1:0] adc_ovld_mask,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////
    typedef struct packed {
        logic [7:0] mon_mask;
        logic [FMLAT_CHM_MSB:FMLAT_CHM_LSB] ch_mask;
        logic [1:0] adc_mask;
        logic [7:0] rdata;
        logic rvalid;
        logic irq;
    } fmlat_state_s;

    fmlat_state_s st_q;
    fmlat_state_s st_d;

    logic [FMLAT_RAW_W-1:0] raw;
    logic [FMLAT_RAW_W-1:0] sync;
    logic [FMLAT_SYS_W-1:0] sys_q;
    logic [FMLAT_MON_W-1:0] mon_q;
    logic [FMLAT_IN_W-1:0] in1_q;
    logic [FMLAT_IN_W-1:0] in2_q;
    logic [FMLAT_OUT_W-1:0] out1_q;
    logic [FMLAT_OUT_W-1:0] out2_q;
    logic [0:0] vbat_q;
    logic rd_sys;
    logic rd_sum;
    logic rd_in1;
    logic rd_in2;
    logic rd_out1;
    logic rd_out2;
    logic rd_mon;
    logic [7:0] summary;
    logic [7:0] rd_mux;
    logic [FMLAT_MON_W-1:0] mon_pend;
    logic [FMLAT_SYS_W-1:0] sys_pend;
    logic [4:0] ch_pend;
    logic any_pend;

    ////////////////////////////////////////////////////////////////////////////
    // detector levels cross into clk
    assign raw = {vbat_low_short_in, out2_fault_in, out1_fault_in, in2_fault_in,
                  in1_fault_in, mon_fault_in, sys_fault_in};

    fmlat_pin_sync #(
        .W(FMLAT_RAW_W)
    ) u_sync (
        .clk(clk),
        .rst(rst),
        .raw(raw),
        .val(sync)
    );

    ////////////////////////////////////////////////////////////////////////////
    // read strobes that clear the latches
    assign rd_sys = reg_rd && (reg_addr == FMLAT_OFS_SYSLAT);
    assign rd_sum = reg_rd && (reg_addr == FMLAT_OFS_SUMMARY);
    assign rd_in1 = reg_rd && (reg_addr == FMLAT_OFS_IN1);
    assign rd_in2 = reg_rd && (reg_addr == FMLAT_OFS_IN2);
    assign rd_out1 = reg_rd && (reg_addr == FMLAT_OFS_OUT1);
    assign rd_out2 = reg_rd && (reg_addr == FMLAT_OFS_OUT2);
    assign rd_mon = reg_rd && (reg_addr == FMLAT_OFS_MONLAT);

    // clock error, loop lock, boost temperature, current and mode-output
    fmlat_event_latch #(
        .W(FMLAT_SYS_W)
    ) u_sys_lat (
        .clk(clk),
        .rst(rst),
        .evt(sync[FMLAT_RAW_SYS +: FMLAT_SYS_W]),
        .clr(rd_sys),
        .q(sys_q)
    );

    fmlat_event_latch #(
        .W(FMLAT_MON_W)
    ) u_mon_lat (
        .clk(clk),
        .rst(rst),
        .evt(sync[FMLAT_RAW_MON +: FMLAT_MON_W]),
        .clr(rd_mon),
        .q(mon_q)
    );

    fmlat_event_latch #(
        .W(FMLAT_IN_W)
    ) u_in1_lat (
        .clk(clk),
        .rst(rst),
        .evt(sync[FMLAT_RAW_IN1 +: FMLAT_IN_W]),
        .clr(rd_in1),
        .q(in1_q)
    );

    fmlat_event_latch #(
        .W(FMLAT_IN_W)
    ) u_in2_lat (
        .clk(clk),
        .rst(rst),
        .evt(sync[FMLAT_RAW_IN2 +: FMLAT_IN_W]),
        .clr(rd_in2),
        .q(in2_q)
    );

    fmlat_event_latch #(
        .W(FMLAT_OUT_W)
    ) u_out1_lat (
        .clk(clk),
        .rst(rst),
        .evt(sync[FMLAT_RAW_OUT1 +: FMLAT_OUT_W]),
        .clr(rd_out1),
        .q(out1_q)
    );

    fmlat_event_latch #(
        .W(FMLAT_OUT_W)
    ) u_out2_lat (
        .clk(clk),
        .rst(rst),
        .evt(sync[FMLAT_RAW_OUT2 +: FMLAT_OUT_W]),
        .clr(rd_out2),
        .q(out2_q)
    );

    // battery short below bias is only released by reading the summary
    fmlat_event_latch #(
        .W(1)
    ) u_vbat_lat (
        .clk(clk),
        .rst(rst),
        .evt(sync[FMLAT_RAW_VBAT +: 1]),
        .clr(rd_sum),
        .q(vbat_q)
    );

    ////////////////////////////////////////////////////////////////////////////
    // channel summary
    assign summary = {|in1_q, |in2_q,
                      |out1_q, |out2_q,
                      vbat_q[0],
                      FMLAT_RSVD3};

    // read data selection; unmapped offsets read zero
    always_comb begin
        unique case (reg_addr)
            FMLAT_OFS_CHMASK: rd_mux = {st_q.ch_mask, FMLAT_RSVD3};
            FMLAT_OFS_MONMASK: rd_mux = st_q.mon_mask;
            FMLAT_OFS_SYSLAT: rd_mux = {sys_q, FMLAT_RSVD3};
            FMLAT_OFS_SUMMARY: rd_mux = summary;
            FMLAT_OFS_IN1: rd_mux = in1_q;
            FMLAT_OFS_IN2: rd_mux = in2_q;
            FMLAT_OFS_OUT1: rd_mux = {out1_q, st_q.adc_mask, FMLAT_RSVD2};
            FMLAT_OFS_OUT2: rd_mux = {out2_q, FMLAT_RSVD4};
            FMLAT_OFS_MONLAT: rd_mux = mon_q;
            default: rd_mux = FMLAT_RDATA_RST;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // pending sources: 1 in a mask bit suppresses the source
    assign mon_pend[FMLAT_MON_GPA_HI] =
        mon_q[FMLAT_MON_GPA_HI] & ~st_q.mon_mask[FMLAT_MON_GPA_HI];
    assign mon_pend[FMLAT_MON_GPA_LO] =
        mon_q[FMLAT_MON_GPA_LO] & ~st_q.mon_mask[FMLAT_MON_GPA_LO];
    assign mon_pend[FMLAT_MON_VAD_UP] =
        mon_q[FMLAT_MON_VAD_UP] & ~st_q.mon_mask[FMLAT_MON_VAD_UP];
    assign mon_pend[FMLAT_MON_VAD_DN] =
        mon_q[FMLAT_MON_VAD_DN] & ~st_q.mon_mask[FMLAT_MON_VAD_DN];
    assign mon_pend[FMLAT_MON_MB_SHORT] =
        mon_q[FMLAT_MON_MB_SHORT] & ~st_q.mon_mask[FMLAT_MON_MB_SHORT];
    assign mon_pend[FMLAT_MON_MB_HI] =
        mon_q[FMLAT_MON_MB_HI] & ~st_q.mon_mask[FMLAT_MON_MB_HI];
    assign mon_pend[FMLAT_MON_MB_LO] =
        mon_q[FMLAT_MON_MB_LO] & ~st_q.mon_mask[FMLAT_MON_MB_LO];
    assign mon_pend[FMLAT_MON_MB_OV] =
        mon_q[FMLAT_MON_MB_OV] & ~st_q.mon_mask[FMLAT_MON_MB_OV];

    assign sys_pend = sys_q & ~sys_event_mask;
    // channel mask bits 7..4 pair with summary bits 7..4, bit 3 with battery short
    assign ch_pend = summary[FMLAT_CHM_MSB:FMLAT_CHM_LSB] & ~st_q.ch_mask;
    assign any_pend = (|mon_pend) | (|sys_pend) | (|ch_pend);

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        st_d = st_q;
        st_d.rvalid = reg_rd;
        if (reg_rd) begin
            st_d.rdata = rd_mux;
        end
        if (reg_wr) begin
            unique case (reg_addr)
                FMLAT_OFS_MONMASK: st_d.mon_mask = reg_wdata;
                FMLAT_OFS_CHMASK: st_d.ch_mask = reg_wdata[FMLAT_CHM_MSB:FMLAT_CHM_LSB];
                FMLAT_OFS_OUT1: st_d.adc_mask = reg_wdata[FMLAT_ADCM_MSB:FMLAT_ADCM_LSB];
                default: st_d.mon_mask = st_q.mon_mask;
            endcase
        end
        st_d.irq = any_pend;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q.mon_mask <= FMLAT_MONMASK_RST;
            st_q.ch_mask <= FMLAT_CHMASK_RST;
            st_q.adc_mask <= FMLAT_ADCMASK_RST;
            st_q.rdata <= FMLAT_RDATA_RST;
            st_q.rvalid <= 1'b0;
            st_q.irq <= 1'b0;
        end else begin
            st_q <= st_d;
        end
    end

    assign reg_rdata = st_q.rdata;
    assign reg_rvalid = st_q.rvalid;
    assign monitor_fault_mask = st_q.mon_mask;
    assign adc_ovld_mask = st_q.adc_mask;
    assign irq = st_q.irq;

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    chk_mask_reset_value: assert property (
        $fell(rst) |-> (st_q.mon_mask == FMLAT_MONMASK_RST && st_q.ch_mask[FMLAT_CHM_LSB]))
        else $error("mask reset value wrong");

    chk_mask_write_back: assert property (
        (reg_wr && reg_addr == FMLAT_OFS_MONMASK) ##1 !reg_wr
        ##1 (reg_rd && reg_addr == FMLAT_OFS_MONMASK)
        |=> (reg_rdata == $past(reg_wdata, 3)))
        else $error("mask readback differs from write");

    chk_latch_read_value: assert property (
        rd_sys |=> (reg_rvalid && reg_rdata == {$past(sys_q), FMLAT_RSVD3}))
        else $error("event latch read value wrong");

    chk_reserved_zero: assert property (
        (rd_sys || rd_sum) |=> (reg_rdata[2:0] == FMLAT_RSVD3))
        else $error("reserved bits not zero");

    chk_read_clears: assert property (
        (rd_sys && sync[FMLAT_RAW_SYS +: FMLAT_SYS_W] == '0) |=> (sys_q == '0))
        else $error("event latch not cleared by read");

    chk_summary_or: assert property (
        rd_sum |=> (reg_rdata[7:4] == {|$past(in1_q), |$past(in2_q),
                                       |$past(out1_q), |$past(out2_q)}))
        else $error("summary does not follow detail latches");

    chk_irq_raise: assert property (
        any_pend |=> irq)
        else $error("interrupt not raised for unmasked latch");

    chk_irq_drop: assert property (
        (!any_pend ##1 !any_pend) |-> !irq)
        else $error("interrupt held with nothing pending");

    chk_vad_masked: assert property (
        (mon_q != '0 && (mon_q & ~st_q.mon_mask) == '0 && sys_pend == '0
         && ch_pend == '0) |=> !irq)
        else $error("masked voice activity raised interrupt");
endmodule // fmlat_top
`default_nettype wire

//--- tb/fmlat_host.sv
/*
 host model for the fault mask and latch block: single register reads and writes.
 assumes one-cycle strobes launched just after a rising edge of clk.
*/
`timescale 1ns/1ns
`default_nettype none
module fmlat_host (
    // clock
    input wire logic clk,
    // register port
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd
);
    logic [7:0] exp_q[$];

    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // reserved bits are only ever sent as zero
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        // released lines do not keep the last value
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask

    // notes the expected value, the bench pops it when read data appears
    task automatic read_reg(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        exp_q.push_back(e);
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
    endtask
endmodule // fmlat_host
`default_nettype wire

//--- tb/fmlat_test.sv
/*
 self-checking bench for the fault mask and latch block.
 assumes the host model drives the register port and the bench drives fault levels.
*/
`timescale 1ns/1ns
`default_nettype none
module fmlat_test
    import fmlat_pkg::*;
;
    logic clk, rst, reg_wr, reg_rd, reg_rvalid, vbat_low_short_in, irq;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, mon_fault_in, in1_fault_in, in2_fault_in;
    logic [7:0] monitor_fault_mask, r, c1, c2;
    logic [7:3] sys_fault_in, sys_event_mask;
    logic [7:4] out1_fault_in, out2_fault_in;
    logic [3:0] o1, o2;
    logic [1:0] adc_ovld_mask;
    logic [31:0] seed;
    int mismatches, checks_done;

    fmlat_host u_host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd));

    fmlat_top u_dut (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
        .sys_fault_in(sys_fault_in), .mon_fault_in(mon_fault_in),
        .in1_fault_in(in1_fault_in), .in2_fault_in(in2_fault_in),
        .out1_fault_in(out1_fault_in), .out2_fault_in(out2_fault_in),
        .vbat_low_short_in(vbat_low_short_in), .sys_event_mask(sys_event_mask),
        .monitor_fault_mask(monitor_fault_mask), .adc_ovld_mask(adc_ovld_mask), .irq(irq));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic check_data(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_flag(input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic complete_run;
        if (mismatches == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // read data checker: oldest note against each valid pulse
    always @(posedge clk) begin
        if (reg_rvalid === 1'b1) begin
            check_data(reg_rdata, u_host.exp_q.size() > 0 ? u_host.exp_q.pop_front() : 8'hxx);
        end
    end

    initial begin
        cyc(20000);
        mismatches++;
        complete_run;
    end

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        seed = 32'hafe17f7e;
        rst = 1'b1;
        sys_fault_in = 5'h00;
        sys_event_mask = 5'h00;
        mon_fault_in = 8'h00;
        in1_fault_in = 8'h00;
        in2_fault_in = 8'h00;
        out1_fault_in = 4'h0;
        out2_fault_in = 4'h0;
        vbat_low_short_in = 1'b0;
        cyc(3);
        rst <= 1'b0;
        check_data(monitor_fault_mask, 8'h30);
        u_host.read_reg(FMLAT_OFS_MONMASK, 8'h30);
        u_host.read_reg(FMLAT_OFS_SYSLAT, 8'h00);
        u_host.read_reg(FMLAT_OFS_SUMMARY, 8'h00);
        u_host.read_reg(8'h3f, 8'h00);
        u_host.write_reg(FMLAT_OFS_SYSLAT, 8'hf8);
        u_host.read_reg(FMLAT_OFS_SYSLAT, 8'h00);
        // each monitor mask bit in turn, odd bits masked and even bits unmasked
        for (int i = 0; i < 8; i++) begin
            r = 8'($random(seed));
            r[i] = i[0];
            u_host.write_reg(FMLAT_OFS_MONMASK, r);
            u_host.read_reg(FMLAT_OFS_MONMASK, r);
            check_data(monitor_fault_mask, r);
            mon_fault_in <= 8'(1 << i);
            cyc(7);
            check_flag(irq, ~r[i]);
            mon_fault_in <= 8'h00;
            cyc(6);
            u_host.read_reg(FMLAT_OFS_MONLAT, 8'(1 << i));
            u_host.read_reg(FMLAT_OFS_MONLAT, 8'h00);
            cyc(2);
            check_flag(irq, 1'b0);
        end
        // each system event, read while present and after removal
        for (int i = 3; i < 8; i++) begin
            r = 8'($random(seed));
            r[i] = i[0];
            sys_event_mask <= r[7:3];
            sys_fault_in <= 5'(1 << (i - 3));
            cyc(7);
            check_flag(irq, ~r[i]);
            u_host.read_reg(FMLAT_OFS_SYSLAT, 8'(1 << i));
            u_host.read_reg(FMLAT_OFS_SYSLAT, 8'(1 << i));
            sys_fault_in <= 5'h00;
            cyc(6);
            u_host.read_reg(FMLAT_OFS_SYSLAT, 8'(1 << i));
            u_host.read_reg(FMLAT_OFS_SYSLAT, 8'h00);
        end
        // battery short below bias: masked after reset, then let through
        u_host.read_reg(FMLAT_OFS_CHMASK, 8'h08);
        u_host.write_reg(FMLAT_OFS_OUT1, 8'h0c);
        u_host.read_reg(FMLAT_OFS_OUT1, 8'h0c);
        check_data({6'h00, adc_ovld_mask}, 8'h03);
        vbat_low_short_in <= 1'b1;
        cyc(7);
        check_flag(irq, 1'b0);
        u_host.write_reg(FMLAT_OFS_CHMASK, 8'h00);
        cyc(3);
        check_flag(irq, 1'b1);
        vbat_low_short_in <= 1'b0;
        cyc(6);
        u_host.read_reg(FMLAT_OFS_SUMMARY, 8'h08);
        u_host.read_reg(FMLAT_OFS_SUMMARY, 8'h00);
        cyc(3);
        check_flag(irq, 1'b0);
        u_host.write_reg(FMLAT_OFS_CHMASK, 8'h08);
        // channel summary from detail latches
        c1 = 8'($random(seed)) | 8'h01;
        c2 = 8'($random(seed)) | 8'h80;
        o1 = 4'($random(seed)) | 4'h1;
        o2 = 4'($random(seed)) | 4'h8;
        in1_fault_in <= c1;
        in2_fault_in <= c2;
        out1_fault_in <= o1;
        out2_fault_in <= o2;
        vbat_low_short_in <= 1'b1;
        cyc(7);
        check_flag(irq, 1'b1);
        in1_fault_in <= 8'h00;
        in2_fault_in <= 8'h00;
        out1_fault_in <= 4'h0;
        out2_fault_in <= 4'h0;
        vbat_low_short_in <= 1'b0;
        cyc(6);
        u_host.read_reg(FMLAT_OFS_SUMMARY, 8'hf8);
        u_host.read_reg(FMLAT_OFS_SUMMARY, 8'hf0);
        u_host.read_reg(FMLAT_OFS_IN1, c1);
        u_host.read_reg(FMLAT_OFS_IN2, c2);
        u_host.read_reg(FMLAT_OFS_OUT1, {o1, 4'hc});
        u_host.read_reg(FMLAT_OFS_OUT2, {o2, 4'h0});
        u_host.read_reg(FMLAT_OFS_SUMMARY, 8'h00);
        cyc(4);
        check_flag(irq, 1'b0);
        check_flag(u_host.exp_q.size() == 0, 1'b1);
        complete_run;
    end
endmodule // fmlat_test
`default_nettype wire
